// ==== shared/rxf_pkg.sv ====
/*
  Constants for the receive acceptance filter and buffer select block:
  sizes, register indices, field positions, reset values and encodings.
  Assumes a 16-bit register port addressed by word index.
*/
package rxf_pkg;
  // sizes
  localparam int NUM_FILTERS = 16;
  localparam int NUM_MASKS = 3;
  localparam int NUM_BUFFERS = 32;
  localparam int NUM_DIR_BUFFERS = 8;
  localparam int SID_W = 11;
  localparam int EID_W = 18;
  localparam int PTR_W = 4;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  // register indices (word addresses)
  localparam logic [5:0] FILTER_EN_REG = 6'h00;
  localparam logic [5:0] MASK_SEL_LO_REG = 6'h01;
  localparam logic [5:0] MASK_SEL_HI_REG = 6'h02;
  localparam logic [5:0] POINTER_REG_A = 6'h03;
  localparam logic [5:0] FIFO_CONTROL_REG = 6'h07;
  localparam logic [5:0] FULL_FLAGS_LO_REG = 6'h08;
  localparam logic [5:0] FULL_FLAGS_HI_REG = 6'h09;
  localparam logic [5:0] OVERFLOW_FLAGS_LO_REG = 6'h0A;
  localparam logic [5:0] OVERFLOW_FLAGS_HI_REG = 6'h0B;
  localparam logic [5:0] INTERRUPT_FLAG_REG = 6'h0C;
  localparam logic [5:0] BUFFER_PAIR_CONTROL_REG = 6'h0D;
  localparam logic [5:0] MASK_STD_ID_REG = 6'h11;
  localparam logic [5:0] MASK_EXT_ID_REG = 6'h14;
  localparam logic [5:0] FILTER_STD_ID_REG = 6'h20;
  localparam logic [5:0] FILTER_EXT_ID_REG = 6'h30;

  // field positions
  localparam int SID_LSB = 5;
  localparam int FMT_BIT = 3;
  localparam int EID_HI_LSB = 0;
  localparam int BUF_COUNT_LSB = 13;
  localparam int DIR_BIT = 7;
  localparam int RTR_EN_BIT = 5;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;

  // encodings
  localparam logic [1:0] MASK_SEL_RESERVED = 2'h3;
  localparam logic [3:0] PTR_FIFO = 4'hF;
  // buffer count per buffer_count_select code, code 0 at the right
  localparam logic [7:0][5:0] BUF_COUNT_TAB = {6'h20, 6'h20, 6'h18, 6'h10, 6'h0C, 6'h08, 6'h06, 6'h04};

  // reset values
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [2:0] BUF_COUNT_RESET = 3'h0;
endpackage

// ==== verilog/id_match_filter.sv ====
/*
  One acceptance filter: masked identifier compare plus format check.
  Assumes the selected mask is already muxed in by the caller.
*/
`timescale 1ns/100ps
`default_nettype none
module id_match_filter #(
  parameter int SID_W = 11,
  parameter int EID_W = 18
) (
  input wire logic enable,
  input wire logic mask_ok,
  input wire logic [SID_W-1:0] filter_sid,
  input wire logic [EID_W-1:0] filter_eid,
  input wire logic ext_format_select,
  input wire logic [SID_W-1:0] mask_sid,
  input wire logic [EID_W-1:0] mask_eid,
  input wire logic format_check_enable,
  input wire logic [SID_W-1:0] frame_sid,
  input wire logic [EID_W-1:0] frame_eid,
  input wire logic frame_ext,
  output logic hit
);
  logic sid_ok; // standard part matches
  logic eid_ok; // extended part matches
  logic fmt_ok; // frame format accepted

  // mask bit 0 accepts any bit; mask bit 1 needs equality
  assign sid_ok = ~|((filter_sid ^ frame_sid) & mask_sid);
  // extended part only counts for extended frames
  assign eid_ok = ~frame_ext | ~|((filter_eid ^ frame_eid) & mask_eid);
  // with the check off, both formats pass
  assign fmt_ok = ~format_check_enable | (ext_format_select == frame_ext);
  // disabled filter or reserved mask never hits
  assign hit = enable & mask_ok & sid_ok & eid_ok & fmt_ok;
endmodule
`default_nettype wire

// ==== verilog/lowest_first_pick.sv ====
/*
  Fixed priority picker: index of the lowest set request bit.
  Pure combinational, no assumptions on the caller.
*/
`timescale 1ns/100ps
`default_nettype none
module lowest_first_pick #(
  parameter int N = 16,
  parameter int W = 4
) (
  input wire logic [N-1:0] req,
  output logic found,
  output logic [W-1:0] index
);
  // scan from the top so the lowest set bit wins last
  always_comb begin
    found = 1'b0;
    index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        index = W'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ==== verilog/rx_filter_select.sv ====
/*
  Receive acceptance filtering and destination buffer selection.
  Holds the filter, mask, pointer and flag registers, matches each
  finished frame against sixteen filters and hands the chosen buffer
  index to the receive DMA channel.
  Assumes: the protocol engine gives one frame_valid pulse per frame on
  clk; the FIFO logic outside supplies its write index and steps on
  fifo_advance; the DMA channel runs in indirect mode off dma_buf_index.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_filter_select #(
  parameter int NUM_FILTERS = 16,
  parameter int NUM_BUFFERS = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic frame_valid,
  input wire logic frame_ext,
  input wire logic [10:0] frame_sid,
  input wire logic [17:0] frame_eid,
  input wire logic [4:0] fifo_wr_index,
  output logic fifo_advance,
  output logic dma_req,
  output logic [4:0] dma_buf_index,
  output logic remote_answer_req,
  output logic [2:0] remote_answer_buf,
  output logic rx_buffer_irq_flag,
  output logic rx_overflow_irq_flag
);
  localparam int FW = $clog2(NUM_FILTERS); // filter index width

  // software registers
  logic [15:0] filter_enable_bit_r; // one enable per filter
  logic [31:0] mask_select_r; // two bits per filter
  logic [63:0] filter_buffer_pointer_r; // four bits per filter
  logic [2:0] buffer_count_select_r; // how many buffers exist
  logic [15:0] pair_ctrl_r [4]; // direction and auto answer, two buffers each
  logic [15:0] mask_sid_r [rxf_pkg::NUM_MASKS]; // mask standard part
  logic [15:0] mask_eid_r [rxf_pkg::NUM_MASKS]; // mask extended low part
  logic [15:0] filt_sid_r [NUM_FILTERS]; // filter standard part
  logic [15:0] filt_eid_r [NUM_FILTERS]; // filter extended low part
  // hardware state
  logic [NUM_BUFFERS-1:0] buffer_full_flag_r; // one bit per buffer
  logic [NUM_BUFFERS-1:0] buffer_overflow_flag_r;
  logic [NUM_BUFFERS-1:0] full_nxt;
  logic [NUM_BUFFERS-1:0] ovf_nxt;
  logic rx_irq_r;
  logic ovf_irq_r;
  logic [15:0] reg_rdata_r;
  logic dma_req_r;
  logic [4:0] dma_buf_r;
  logic fifo_adv_r;
  logic rtr_req_r;
  logic [2:0] rtr_buf_r;

  // per-filter results
  logic [NUM_FILTERS-1:0] hit;
  logic [NUM_FILTERS-1:0] cand; // hit whose target can take the frame
  logic [NUM_FILTERS-1:0] serve_rtr; // hit on an auto answer buffer
  logic [NUM_FILTERS-1:0] use_fifo;
  logic [NUM_FILTERS-1:0] usable;
  logic [4:0] tgt [NUM_FILTERS];
  logic [5:0] buf_count; // buffers configured
  logic cand_found;
  logic [FW-1:0] cand_idx;
  logic hit_found;
  logic [FW-1:0] hit_idx;

  // buffer count decode from the fifo control field
  assign buf_count = rxf_pkg::BUF_COUNT_TAB[buffer_count_select_r];

  // one compare unit and target decode per filter
  for (genvar i = 0; i < NUM_FILTERS; i++) begin : g_filt
    logic [1:0] sel;
    logic [15:0] msid;
    logic [15:0] meid;
    logic [3:0] ptr;
    logic is_tx;
    logic rtr_en;
    assign sel = mask_select_r[2*i +: 2];
    // reserved selector reads as an all-zero mask, and mask_ok blocks it
    assign msid = (sel == rxf_pkg::MASK_SEL_RESERVED) ? 16'h0000 : mask_sid_r[sel];
    assign meid = (sel == rxf_pkg::MASK_SEL_RESERVED) ? 16'h0000 : mask_eid_r[sel];
    assign ptr = filter_buffer_pointer_r[4*i +: 4];
    // 1111 goes to the FIFO slot; the pointer alone reaches 0..14 only
    assign use_fifo[i] = (ptr == rxf_pkg::PTR_FIFO);
    assign tgt[i] = use_fifo[i] ? fifo_wr_index : {1'b0, ptr};
    // a target beyond the configured count holds no buffer
    assign usable[i] = ({1'b0, tgt[i]} < buf_count);
    // only buffers 0..7 carry a direction bit
    assign is_tx = (tgt[i] < 5'h08) & pair_ctrl_r[tgt[i][2:1]][8*tgt[i][0] + rxf_pkg::DIR_BIT];
    assign rtr_en = pair_ctrl_r[tgt[i][2:1]][8*tgt[i][0] + rxf_pkg::RTR_EN_BIT];
    assign serve_rtr[i] = hit[i] & usable[i] & is_tx & rtr_en;
    // receive-direction buffer that is still empty, or an auto answer hit
    assign cand[i] = (hit[i] & usable[i] & ~is_tx & ~buffer_full_flag_r[tgt[i]]) | serve_rtr[i];
    id_match_filter #(
      .SID_W(rxf_pkg::SID_W),
      .EID_W(rxf_pkg::EID_W)
    ) u_match (
      .enable(filter_enable_bit_r[i]),
      .mask_ok(sel != rxf_pkg::MASK_SEL_RESERVED),
      .filter_sid(filt_sid_r[i][rxf_pkg::SID_LSB +: 11]),
      .filter_eid({filt_sid_r[i][rxf_pkg::EID_HI_LSB +: 2], filt_eid_r[i]}),
      .ext_format_select(filt_sid_r[i][rxf_pkg::FMT_BIT]),
      .mask_sid(msid[rxf_pkg::SID_LSB +: 11]),
      .mask_eid({msid[rxf_pkg::EID_HI_LSB +: 2], meid}),
      .format_check_enable(msid[rxf_pkg::FMT_BIT]),
      .frame_sid(frame_sid),
      .frame_eid(frame_eid),
      .frame_ext(frame_ext),
      .hit(hit[i])
    );
  end

  // lowest filter that can take the frame
  lowest_first_pick #(
    .N(NUM_FILTERS),
    .W(FW)
  ) u_pick_cand (
    .req(cand),
    .found(cand_found),
    .index(cand_idx)
  );

  // lowest hit whose target exists, for the overflow case
  lowest_first_pick #(
    .N(NUM_FILTERS),
    .W(FW)
  ) u_pick_hit (
    .req(hit & usable),
    .found(hit_found),
    .index(hit_idx)
  );

  // decision for the current frame
  logic do_store; // frame goes to a buffer
  logic do_rtr; // frame triggers a remote answer
  logic do_ovf; // frame lost on a busy buffer
  logic [4:0] win_buf;
  logic [4:0] ovf_buf;
  logic win_fifo;
  logic ovf_fifo;
  assign win_buf = tgt[cand_idx];
  assign ovf_buf = tgt[hit_idx];
  assign win_fifo = use_fifo[cand_idx];
  assign ovf_fifo = use_fifo[hit_idx];
  assign do_rtr = frame_valid & cand_found & serve_rtr[cand_idx];
  assign do_store = frame_valid & cand_found & ~serve_rtr[cand_idx];
  // a target past the buffer count is dropped silently
  assign do_ovf = frame_valid & ~cand_found & hit_found & usable[hit_idx];

  // software write strobes for the flag registers
  logic wr_full_lo;
  logic wr_full_hi;
  logic wr_ovf_lo;
  logic wr_ovf_hi;
  assign wr_full_lo = reg_wr & (reg_addr == rxf_pkg::FULL_FLAGS_LO_REG);
  assign wr_full_hi = reg_wr & (reg_addr == rxf_pkg::FULL_FLAGS_HI_REG);
  assign wr_ovf_lo = reg_wr & (reg_addr == rxf_pkg::OVERFLOW_FLAGS_LO_REG);
  assign wr_ovf_hi = reg_wr & (reg_addr == rxf_pkg::OVERFLOW_FLAGS_HI_REG);

  // flags: software writes zero to clear, a hardware set wins the same cycle
  always_comb begin
    full_nxt = buffer_full_flag_r;
    ovf_nxt = buffer_overflow_flag_r;
    if (wr_full_lo) begin
      full_nxt[15:0] = full_nxt[15:0] & reg_wdata;
    end
    if (wr_full_hi) begin
      full_nxt[31:16] = full_nxt[31:16] & reg_wdata;
    end
    if (wr_ovf_lo) begin
      ovf_nxt[15:0] = ovf_nxt[15:0] & reg_wdata;
    end
    if (wr_ovf_hi) begin
      ovf_nxt[31:16] = ovf_nxt[31:16] & reg_wdata;
    end
    // hardware sets last so they beat a same-cycle clear
    if (do_store) begin
      full_nxt[win_buf] = 1'b1;
    end
    if (do_ovf) begin
      ovf_nxt[ovf_buf] = 1'b1;
    end
  end

  // per-buffer flag storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_full_flag_r <= '0;
      buffer_overflow_flag_r <= '0;
    end else begin
      buffer_full_flag_r <= full_nxt;
      buffer_overflow_flag_r <= ovf_nxt;
    end
  end

  // interrupt flags, cleared by writing zero, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_irq_r <= 1'b0;
      ovf_irq_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == rxf_pkg::INTERRUPT_FLAG_REG) begin
        // writing one keeps the flag, it never sets it
        rx_irq_r <= (reg_wdata[rxf_pkg::IRQ_RX_BIT] & rx_irq_r) | do_store;
        ovf_irq_r <= (reg_wdata[rxf_pkg::IRQ_OVF_BIT] & ovf_irq_r) | do_ovf;
      end else begin
        rx_irq_r <= rx_irq_r | do_store;
        ovf_irq_r <= ovf_irq_r | do_ovf;
      end
    end
  end

  // hand-off to DMA, remote answer and FIFO stepping, one pulse each
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_req_r <= 1'b0;
      dma_buf_r <= 5'h00;
      rtr_req_r <= 1'b0;
      rtr_buf_r <= 3'h0;
      fifo_adv_r <= 1'b0;
    end else begin
      // unmatched frames leave every output quiet
      dma_req_r <= do_store;
      if (do_store) begin
        dma_buf_r <= win_buf;
      end
      rtr_req_r <= do_rtr;
      if (do_rtr) begin
        rtr_buf_r <= win_buf[2:0];
      end
      // the FIFO slot is consumed on store and on loss alike
      fifo_adv_r <= (do_store & win_fifo) | (do_ovf & ovf_fifo);
    end
  end

  // configuration writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_enable_bit_r <= rxf_pkg::REG_RESET;
      mask_select_r <= '0;
      filter_buffer_pointer_r <= '0;
      buffer_count_select_r <= rxf_pkg::BUF_COUNT_RESET;
      for (int k = 0; k < 4; k++) begin
        pair_ctrl_r[k] <= rxf_pkg::REG_RESET;
      end
      for (int k = 0; k < rxf_pkg::NUM_MASKS; k++) begin
        mask_sid_r[k] <= rxf_pkg::REG_RESET;
        mask_eid_r[k] <= rxf_pkg::REG_RESET;
      end
      for (int k = 0; k < NUM_FILTERS; k++) begin
        filt_sid_r[k] <= rxf_pkg::REG_RESET;
        filt_eid_r[k] <= rxf_pkg::REG_RESET;
      end
    end else if (reg_wr) begin
      if (reg_addr == rxf_pkg::FILTER_EN_REG) begin
        filter_enable_bit_r <= reg_wdata;
      end else if (reg_addr == rxf_pkg::MASK_SEL_LO_REG) begin
        mask_select_r[15:0] <= reg_wdata;
      end else if (reg_addr == rxf_pkg::MASK_SEL_HI_REG) begin
        mask_select_r[31:16] <= reg_wdata;
      end else if (reg_addr >= rxf_pkg::POINTER_REG_A && reg_addr < rxf_pkg::POINTER_REG_A + 6'h04) begin
        filter_buffer_pointer_r[16*(reg_addr - rxf_pkg::POINTER_REG_A) +: 16] <= reg_wdata;
      end else if (reg_addr == rxf_pkg::FIFO_CONTROL_REG) begin
        buffer_count_select_r <= reg_wdata[rxf_pkg::BUF_COUNT_LSB +: 3];
      end else if (reg_addr >= rxf_pkg::BUFFER_PAIR_CONTROL_REG &&
                   reg_addr < rxf_pkg::BUFFER_PAIR_CONTROL_REG + 6'h04) begin
        // send requests live in the transmit logic; here only direction and auto answer matter
        pair_ctrl_r[2'(reg_addr - rxf_pkg::BUFFER_PAIR_CONTROL_REG)] <= reg_wdata;
      end else if (reg_addr >= rxf_pkg::MASK_STD_ID_REG && reg_addr < rxf_pkg::MASK_EXT_ID_REG) begin
        mask_sid_r[2'(reg_addr - rxf_pkg::MASK_STD_ID_REG)] <= reg_wdata;
      end else if (reg_addr >= rxf_pkg::MASK_EXT_ID_REG && reg_addr < rxf_pkg::MASK_EXT_ID_REG + 6'h03) begin
        mask_eid_r[2'(reg_addr - rxf_pkg::MASK_EXT_ID_REG)] <= reg_wdata;
      end else if (reg_addr >= rxf_pkg::FILTER_STD_ID_REG && reg_addr < rxf_pkg::FILTER_EXT_ID_REG) begin
        filt_sid_r[reg_addr[3:0]] <= reg_wdata;
      end else if (reg_addr >= rxf_pkg::FILTER_EXT_ID_REG) begin
        filt_eid_r[reg_addr[3:0]] <= reg_wdata;
      end
    end
  end

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == rxf_pkg::FILTER_EN_REG) begin
        reg_rdata_r <= filter_enable_bit_r;
      end else if (reg_addr == rxf_pkg::MASK_SEL_LO_REG) begin
        reg_rdata_r <= mask_select_r[15:0];
      end else if (reg_addr == rxf_pkg::MASK_SEL_HI_REG) begin
        reg_rdata_r <= mask_select_r[31:16];
      end else if (reg_addr >= rxf_pkg::POINTER_REG_A && reg_addr < rxf_pkg::POINTER_REG_A + 6'h04) begin
        reg_rdata_r <= filter_buffer_pointer_r[16*(reg_addr - rxf_pkg::POINTER_REG_A) +: 16];
      end else if (reg_addr == rxf_pkg::FIFO_CONTROL_REG) begin
        reg_rdata_r <= {buffer_count_select_r, 13'h0000};
      end else if (reg_addr == rxf_pkg::FULL_FLAGS_LO_REG) begin
        reg_rdata_r <= buffer_full_flag_r[15:0];
      end else if (reg_addr == rxf_pkg::FULL_FLAGS_HI_REG) begin
        reg_rdata_r <= buffer_full_flag_r[31:16];
      end else if (reg_addr == rxf_pkg::OVERFLOW_FLAGS_LO_REG) begin
        reg_rdata_r <= buffer_overflow_flag_r[15:0];
      end else if (reg_addr == rxf_pkg::OVERFLOW_FLAGS_HI_REG) begin
        reg_rdata_r <= buffer_overflow_flag_r[31:16];
      end else if (reg_addr == rxf_pkg::INTERRUPT_FLAG_REG) begin
        reg_rdata_r <= {14'h0000, ovf_irq_r, rx_irq_r};
      end else if (reg_addr >= rxf_pkg::BUFFER_PAIR_CONTROL_REG &&
                   reg_addr < rxf_pkg::BUFFER_PAIR_CONTROL_REG + 6'h04) begin
        reg_rdata_r <= pair_ctrl_r[2'(reg_addr - rxf_pkg::BUFFER_PAIR_CONTROL_REG)];
      end else if (reg_addr >= rxf_pkg::MASK_STD_ID_REG && reg_addr < rxf_pkg::MASK_EXT_ID_REG) begin
        reg_rdata_r <= mask_sid_r[2'(reg_addr - rxf_pkg::MASK_STD_ID_REG)];
      end else if (reg_addr >= rxf_pkg::MASK_EXT_ID_REG && reg_addr < rxf_pkg::MASK_EXT_ID_REG + 6'h03) begin
        reg_rdata_r <= mask_eid_r[2'(reg_addr - rxf_pkg::MASK_EXT_ID_REG)];
      end else if (reg_addr >= rxf_pkg::FILTER_STD_ID_REG && reg_addr < rxf_pkg::FILTER_EXT_ID_REG) begin
        reg_rdata_r <= filt_sid_r[reg_addr[3:0]];
      end else if (reg_addr >= rxf_pkg::FILTER_EXT_ID_REG) begin
        reg_rdata_r <= filt_eid_r[reg_addr[3:0]];
      end else begin
        reg_rdata_r <= 16'h0000;
      end
    end else begin
      // read data stand only in the cycle after the strobe
      reg_rdata_r <= 16'h0000;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = reg_rdata_r;
  assign dma_req = dma_req_r;
  assign dma_buf_index = dma_buf_r;
  assign fifo_advance = fifo_adv_r;
  assign remote_answer_req = rtr_req_r;
  assign remote_answer_buf = rtr_buf_r;
  assign rx_buffer_irq_flag = rx_irq_r;
  assign rx_overflow_irq_flag = ovf_irq_r;
endmodule
`default_nettype wire

// ==== testbench/rxf_checker.sv ====
/* port checker for the receive filter block, bound into every instance
   assumes one clock domain with an asynchronous active-low reset */
`timescale 1ns/100ps
`default_nettype none
module rxf_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [5:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic frame_valid,
  input wire logic [4:0] fifo_wr_index,
  input wire logic fifo_advance,
  input wire logic dma_req,
  input wire logic [4:0] dma_buf_index,
  input wire logic remote_answer_req,
  input wire logic rx_buffer_irq_flag,
  input wire logic rx_overflow_irq_flag
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  one_kind_a: assert property (!(dma_req && remote_answer_req))
    else $error("store and remote answer together");
  req_cause_a: assert property (dma_req |-> $past(frame_valid))
    else $error("dma request without a frame");
  rx_irq_a: assert property (dma_req |-> rx_buffer_irq_flag)
    else $error("store without receive flag");
  ovf_cause_a: assert property ($rose(rx_overflow_irq_flag) |-> $past(frame_valid))
    else $error("overflow flag without a frame");
  rx_clear_a: assert property ($fell(rx_buffer_irq_flag) |-> $past(reg_wr) && $past(reg_addr) == 6'h0C)
    else $error("receive flag dropped without a write");
  fifo_idx_a: assert property (dma_req && fifo_advance |-> dma_buf_index == $past(fifo_wr_index))
    else $error("fifo store to the wrong slot");
  direct_idx_a: assert property (dma_req && !fifo_advance |-> dma_buf_index < 5'h0F)
    else $error("direct store above buffer 14");
  idx_hold_a: assert property (!dma_req |-> $stable(dma_buf_index))
    else $error("buffer index moved without request");
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
endmodule
bind rx_filter_select rxf_checker chk (.clk, .rst_n, .reg_wr, .reg_addr, .reg_rd, .reg_rdata, .frame_valid,
  .fifo_wr_index, .fifo_advance, .dma_req, .dma_buf_index, .remote_answer_req, .rx_buffer_irq_flag,
  .rx_overflow_irq_flag);
`default_nettype wire

// ==== testbench/rx_dma_model.sv ====
/* receive DMA partner: one copy per request, owns the FIFO write slot
   assumes the FIFO spans buffers FIFO_FIRST to FIFO_LAST */
`timescale 1ns/100ps
`default_nettype none
module rx_dma_model #(
  parameter logic [4:0] FIFO_FIRST = 5'h0F,
  parameter logic [4:0] FIFO_LAST = 5'h1F
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dma_req,
  input wire logic [4:0] dma_buf_index,
  input wire logic fifo_advance,
  output logic [4:0] fifo_wr_index,
  output var int copies
);
  // slot steps once per consumed slot, stored or lost, then wraps
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) fifo_wr_index <= FIFO_FIRST;
    else if (fifo_advance) fifo_wr_index <= (fifo_wr_index == FIFO_LAST) ? FIFO_FIRST : fifo_wr_index + 5'h01;
  // indirect mode: destination is only the index beside the request
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) copies <= 0;
    else if (dma_req) copies <= copies + 1;
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/* self-checking bench: register and frame drivers, reference model
   assumes the DMA partner supplies the FIFO write slot */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk, rst_n, reg_wr, reg_rd, fv, fx, fifo_advance, dma_req, rem_req, rx_irq, ov_irq;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d, lf, en;
  logic [10:0] sid;
  logic [17:0] eid;
  logic [4:0] fifo_wr_index, dma_buf_index;
  logic [2:0] rem_buf;
  int n_fail, checks_done, copies, stores, kind, idx, cnt;
  // shadow of filters, masks, buffer modes and flags
  logic [3:0] ptr [16] = '{default: 4'h0};
  logic [1:0] msel [16] = '{default: 2'h0};
  logic [28:0] fid [16], mid [3];
  logic [28:0] base [4] = '{{11'h123, 18'h0}, {11'h456, 18'h2ABC0}, {11'h0F0, 18'h0}, {11'h70F, 18'h0}};
  logic [5:0] ra [4] = '{6'h00, 6'h07, 6'h0C, 6'h1F};
  bit fxs [16], mc [3], dir [8], aa [8], rxi, ovi;
  logic [31:0] full, ovf;
  int cnt_tab [8] = '{4, 6, 8, 12, 16, 24, 32, 32};
  rx_filter_select dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .frame_valid(fv),
    .frame_ext(fx), .frame_sid(sid), .frame_eid(eid), .fifo_wr_index, .fifo_advance, .dma_req, .dma_buf_index,
    .remote_answer_req(rem_req), .remote_answer_buf(rem_buf), .rx_buffer_irq_flag(rx_irq),
    .rx_overflow_irq_flag(ov_irq));
  rx_dma_model dma (.clk, .rst_n, .dma_req, .dma_buf_index, .fifo_advance, .fifo_wr_index, .copies);
  // 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // expected outcome from the shadow state seen in the frame cycle
  function automatic void predict(input logic [28:0] id, input bit x);
    logic [28:0] m;
    int t, lo;
    lo = -1;
    kind = 0;
    for (int i = 0; i < 16; i++) begin
      if (!en[i] || msel[i] == 2'h3) continue;
      m = x ? mid[msel[i]] : {mid[msel[i]][28:18], 18'h0};
      if (((id ^ fid[i]) & m) != 0 || (mc[msel[i]] && fxs[i] != x)) continue;
      t = (ptr[i] == 4'hF) ? int'(fifo_wr_index) : int'(ptr[i]);
      if (t >= cnt) continue;
      if (lo < 0) lo = t;
      if (t < 8 && dir[t]) begin
        if (!aa[t]) continue;
        kind = 3;
        idx = t;
        return;
      end
      if (!full[t]) begin
        kind = 1;
        idx = t;
        full[t] = 1'b1;
        rxi = 1'b1;
        stores++;
        return;
      end
    end
    if (lo >= 0) begin
      kind = 2;
      ovf[lo] = 1'b1;
      ovi = 1'b1;
    end
  endfunction
  task automatic frame(input logic [28:0] id, input bit x);
    @(posedge clk);
    fv <= 1'b1;
    fx <= x;
    {sid, eid} <= id;
    #1 predict(id, x);
    @(posedge clk);
    fv <= 1'b0;
    #1 chk("dma_req", kind == 1, dma_req);
    if (kind == 1) chk("dma_buf_index", idx, dma_buf_index);
    chk("remote_req", kind == 3, rem_req);
    if (kind == 3) chk("remote_buf", idx, rem_buf);
    chk("rx_irq", rxi, rx_irq);
    chk("ovf_irq", ovi, ov_irq);
  endtask
  task automatic setf(input int i, input logic [28:0] id, input bit x, input logic [1:0] m, input logic [3:0] p);
    int b;
    fid[i] = id;
    fxs[i] = x;
    msel[i] = m;
    ptr[i] = p;
    b = i / 4 * 4;
    wr(6'h20 + 6'(i), {id[28:18], 1'b0, x, 1'b0, id[17:16]});
    wr(6'h30 + 6'(i), id[15:0]);
    wr(6'h03 + 6'(i / 4), {ptr[b + 3], ptr[b + 2], ptr[b + 1], ptr[b]});
    b = i / 8 * 8;
    for (int j = 0; j < 8; j++) d[2 * j +: 2] = msel[b + j];
    wr(6'h01 + 6'(i / 8), d);
  endtask
  task automatic setm(input int k, input logic [28:0] id, input bit c);
    mid[k] = id;
    mc[k] = c;
    wr(6'h11 + 6'(k), {id[28:18], 1'b0, c, 1'b0, id[17:16]});
    wr(6'h14 + 6'(k), id[15:0]);
  endtask
  // software clears every flag by writing zeros
  task automatic clr;
    for (int a = 8; a < 13; a++) wr(6'(a), 16'h0000);
    {full, ovf, rxi, ovi} = '0;
  endtask
  task automatic flags;
    logic [15:0] v [5];
    v = '{full[15:0], full[31:16], ovf[15:0], ovf[31:16], {14'h0, ovi, rxi}};
    for (int a = 0; a < 5; a++) begin
      rd(6'h08 + 6'(a));
      chk("flag register", v[a], d);
    end
  endtask
  // bounded run: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run;
  end
  initial begin
    {reg_wr, reg_rd, fv, fx, reg_addr, reg_wdata, sid, eid} = '0;
    {n_fail, checks_done, stores, en, full, ovf, rxi, ovi} = '0;
    rst_n = 1'b0;
    cnt = 4;
    lf = 16'h6097;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wr(6'h1F, 16'hFFFF);
    wr(6'h0C, 16'hFFFF);
    for (int a = 0; a < 4; a++) begin
      rd(ra[a]);
      chk("reset or unmapped", 16'h0000, d);
    end
    setm(0, 29'h1FFFFFFF, 1'b1);
    setm(1, 29'h0, 1'b0);
    setm(2, {11'h7FF, 18'h3FFC0}, 1'b1);
    setf(15, 29'h0, 1'b0, 2'h1, 4'h5);
    en = 16'h8000;
    wr(6'h00, en);
    // every buffer count code against a buffer 5 target
    for (int c = 0; c < 8; c++) begin
      clr;
      cnt = cnt_tab[c];
      wr(6'h07, {3'(c), 13'h0});
      frame({11'h5A5, 18'h0}, 1'b0);
    end
    en = 16'h0040;
    wr(6'h00, en);
    // all four selector codes on one near-miss identifier
    for (int m = 0; m < 4; m++) begin
      setf(6, {11'h2AA, 18'h15555}, 1'b1, 2'(m), 4'h8);
      clr;
      frame({11'h2AA, 18'h15554}, 1'b1);
    end
    setf(0, base[0], 1'b0, 2'h0, 4'h9);
    setf(1, base[0], 1'b0, 2'h0, 4'hA);
    setf(2, base[1], 1'b1, 2'h2, 4'hF);
    setf(3, base[2], 1'b0, 2'h0, 4'h1);
    setf(4, base[3], 1'b0, 2'h0, 4'h2);
    // buffer 1 answers remotes, buffer 2 sends; send request never set on a receiver
    wr(6'h0D, 16'hA000);
    wr(6'h0E, 16'h0080);
    {dir[1], aa[1], dir[2]} = 3'h7;
    en = 16'h001F;
    wr(6'h00, en);
    clr;
    repeat (3) frame(base[0], 1'b0);
    frame(base[0], 1'b1);
    frame(base[2], 1'b0);
    frame(base[3], 1'b0);
    flags;
    for (int n = 0; n < 48; n++) begin
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      if (n % 8 == 0) clr;
      frame(base[lf[1:0]] ^ (lf[2] ? {23'h0, lf[15:10]} : 29'h0) ^ (lf[3] ? 29'h40000 : 29'h0), lf[4]);
    end
    flags;
    chk("dma copies", stores, copies);
    complete_run;
  end
endmodule
`default_nettype wire
